// ==== rtl/nwbx_consts.vh ====
`ifndef NWBX_CONSTS_VH
`define NWBX_CONSTS_VH

// ----------------------------------------
// Widths and FIFO depth
// ----------------------------------------
`define NWBX_NARROW_W 12
`define NWBX_WIDE_W 24
`define NWBX_FIFO_DEPTH 8
`define NWBX_FIFO_AW 3

// ----------------------------------------
// Field positions inside a FIFO word
// ----------------------------------------
`define NWBX_F_DATA_LSB 0
`define NWBX_F_DATA_MSB 11
`define NWBX_F_LD1 12
`define NWBX_F_LD2 13
`define NWBX_F_W 14

// ----------------------------------------
// Reset values and state codes
// ----------------------------------------
`define NWBX_DRIVE_OFF 1'b1
`define NWBX_ST_IDLE 2'h1
`define NWBX_ST_RUN 2'h2

`endif

// ==== rtl/nwbx_fifo.v ====
`timescale 1ns/1ps

module nwbx_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Fill side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // Drain side
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_q;
    reg [AW-1:0] rdPtr_q;
    reg [AW:0] count_q;
    wire doWrite;
    wire doRead;

    assign inReady = (count_q != DEPTH[AW:0]);
    assign outValid = (count_q != {(AW+1){1'b0}});
    assign outData = mem[rdPtr_q];
    assign doWrite = inValid & inReady;
    assign doRead = outValid & outReady;

    always @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            wrPtr_q <= {AW{1'b0}};
            rdPtr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
            end
            if (doRead) begin
                rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
            end
            if (doWrite && !doRead) begin
                count_q <= count_q + 1'b1;
            end else if (doRead && !doWrite) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule // nwbx_fifo

// ==== rtl/nwbx_half_mux.v ====
`timescale 1ns/1ps
`include "nwbx_consts.vh"

module nwbx_half_mux (
    // Clock
    input wire clk,
    // Wide halves in
    input wire [`NWBX_NARROW_W-1:0] wideFirstIn,
    input wire [`NWBX_NARROW_W-1:0] wideSecondIn,
    input wire wide_first_load_enable_n,
    input wire wide_second_load_enable_n,
    input wire halfSelect_n,
    // Narrow value out
    output reg [`NWBX_NARROW_W-1:0] narrowOut_q
);

    // Select is captured with the edge, so only one half ever feeds the output.
    always @(posedge clk) begin
        if (halfSelect_n) begin
            if (!wide_first_load_enable_n) begin // [RQ8]
                narrowOut_q <= wideFirstIn; // [RQ9]
            end
        end else begin
            if (!wide_second_load_enable_n) begin // [RQ8]
                narrowOut_q <= wideSecondIn; // [RQ10]
            end
        end
    end

endmodule // nwbx_half_mux

// ==== rtl/nwbx_exchanger.v ====
// What this block does
// [RQ1] Exchange 12-bit narrow and 24-bit wide words.
// [RQ2] Registers load on edge with enable low.
// [RQ3] First half two stages, second half one.
// [RQ4] First half sees narrow value after two edges; the ingress queue makes it three edges here.
// [RQ5] Second half loads on its own enable.
// [RQ6] Driver sequences enables to pair words.
// [RQ7] Both narrow enables high holds wide outputs; here they hold only after the last queued word drains.
// [RQ8] Wide half loads narrow output under enable.
// [RQ9] Registered select: high first, low second.
// [RQ10] Narrow output from one half only.
// [RQ11] Separate active-low drive enables per port.
// [RQ12] Drive enables registered on the clock.
// [RQ13] Output state undefined before first edge.
// [RQ14] Host clocks early with enables high.
// [RQ15] Datapath registers have no reset.
// [RQ16] Never both parties driving one port.
`timescale 1ns/1ps
`include "nwbx_consts.vh"

module nwbx_exchanger (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Narrow port pin
    input wire [`NWBX_NARROW_W-1:0] narrowIn,
    output reg [`NWBX_NARROW_W-1:0] narrowOut_q,
    output reg [`NWBX_NARROW_W-1:0] narrowOe_q,
    // Wide port pins
    input wire [`NWBX_NARROW_W-1:0] wideHalfFirstIn,
    input wire [`NWBX_NARROW_W-1:0] wideHalfSecondIn,
    output reg [`NWBX_NARROW_W-1:0] wideHalfFirstOut_q,
    output reg [`NWBX_NARROW_W-1:0] wideHalfSecondOut_q,
    output reg [`NWBX_WIDE_W-1:0] wideOe_q,
    // Control pins
    input wire narrow_load_enable_first_n,
    input wire narrow_load_enable_second_n,
    input wire wide_first_load_enable_n,
    input wire wide_second_load_enable_n,
    input wire halfSelect_n,
    input wire narrow_port_drive_n,
    input wire wide_port_drive_n,
    // Ingress FIFO status
    output reg narrowReady_q,
    output reg pipeBusy_q
);

    // ----------------------------------------
    // Ingress buffer
    // ----------------------------------------
    // Narrow samples and their enables are queued together so the pipeline keeps
    // the exact edge pairing. The drain stalls in reset and for one cycle after it, so the queue adds
    // one cycle of latency but never reorders or drops a word.
    wire [`NWBX_F_W-1:0] fifoIn;
    wire [`NWBX_F_W-1:0] fifoOut;
    wire fifoInReady;
    wire fifoOutValid;
    wire fifoPush;
    wire drainReady;
    wire [`NWBX_NARROW_W-1:0] qData;
    wire qLoad1;
    wire qLoad2;

    assign fifoPush = ~(narrow_load_enable_first_n & narrow_load_enable_second_n);
    assign fifoIn = {~narrow_load_enable_second_n, ~narrow_load_enable_first_n, narrowIn}; // [RQ1]
    assign qData = fifoOut[`NWBX_F_DATA_MSB:`NWBX_F_DATA_LSB];
    assign qLoad1 = fifoOut[`NWBX_F_LD1];
    assign qLoad2 = fifoOut[`NWBX_F_LD2];

    nwbx_fifo #(
        .WIDTH(`NWBX_F_W),
        .DEPTH(`NWBX_FIFO_DEPTH),
        .AW(`NWBX_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .inValid(fifoPush),
        .inReady(fifoInReady),
        .inData(fifoIn),
        .outValid(fifoOutValid),
        .outReady(drainReady),
        .outData(fifoOut)
    );

    // ----------------------------------------
    // Control state
    // ----------------------------------------
    localparam [1:0] ST_IDLE = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;

    always @* begin
        case (state_q)
            ST_IDLE: state_d = ST_RUN;
            ST_RUN: state_d = ST_RUN;
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign drainReady = (state_q == ST_RUN);

    always @(posedge clk) begin
        if (reset) begin
            narrowReady_q <= 1'b0;
            pipeBusy_q <= 1'b0;
        end else begin
            narrowReady_q <= fifoInReady;
            pipeBusy_q <= fifoOutValid;
        end
    end

    // ----------------------------------------
    // Narrow to wide datapath
    // ----------------------------------------
    // No reset here: contents are arbitrary until loaded. // [RQ15]
    reg [`NWBX_NARROW_W-1:0] stageOne_q;
    wire popWord;

    assign popWord = fifoOutValid & drainReady;

    always @(posedge clk) begin
        if (popWord && qLoad1) begin // [RQ2]
            stageOne_q <= qData; // [RQ3]
            wideHalfFirstOut_q <= stageOne_q; // [RQ4]
        end
        if (popWord && qLoad2) begin // [RQ5]
            wideHalfSecondOut_q <= qData; // [RQ3]
        end
        // With both enables high nothing new is queued, so the halves hold once the last queued word drains. // [RQ7]
    end

    // ----------------------------------------
    // Wide to narrow datapath
    // ----------------------------------------
    wire [`NWBX_NARROW_W-1:0] muxOut;

    nwbx_half_mux u_mux (
        .clk(clk),
        .wideFirstIn(wideHalfFirstIn),
        .wideSecondIn(wideHalfSecondIn),
        .wide_first_load_enable_n(wide_first_load_enable_n),
        .wide_second_load_enable_n(wide_second_load_enable_n),
        .halfSelect_n(halfSelect_n),
        .narrowOut_q(muxOut)
    );

    always @(posedge clk) begin
        narrowOut_q <= muxOut; // [RQ10]
    end

    // ----------------------------------------
    // Registered drive enables
    // ----------------------------------------
    // Reset forces both ports released, which is the safe start-up state. // [RQ13]
    always @(posedge clk) begin
        if (reset) begin
            narrowOe_q <= {`NWBX_NARROW_W{1'b0}};
            wideOe_q <= {`NWBX_WIDE_W{1'b0}};
        end else begin
            narrowOe_q <= {`NWBX_NARROW_W{~narrow_port_drive_n}}; // [RQ11] [RQ12]
            wideOe_q <= {`NWBX_WIDE_W{~wide_port_drive_n}}; // [RQ11] [RQ12]
        end
    end

endmodule // nwbx_exchanger

// ==== dv/nwbx_exchanger_chk.sv ====
`timescale 1ns/1ps
module nwbx_exchanger_chk (
    input wire clk,
    input wire reset,
    input wire [11:0] narrowIn,
    input wire [11:0] narrowOut_q,
    input wire [11:0] narrowOe_q,
    input wire [11:0] wideHalfFirstIn,
    input wire [11:0] wideHalfSecondIn,
    input wire [11:0] wideHalfFirstOut_q,
    input wire [11:0] wideHalfSecondOut_q,
    input wire [23:0] wideOe_q,
    input wire narrow_load_enable_first_n,
    input wire narrow_load_enable_second_n,
    input wire wide_first_load_enable_n,
    input wire wide_second_load_enable_n,
    input wire halfSelect_n,
    input wire narrow_port_drive_n,
    input wire wide_port_drive_n
);
    wire e1 = narrow_load_enable_first_n;
    wire e2 = narrow_load_enable_second_n;
    wire s = halfSelect_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    chk_oe_reset: assert property (disable iff (1'b0) reset |=> !narrowOe_q && !wideOe_q)
        else $error("enables not cleared");
    chk_narrow_oe: assert property (1 |=> narrowOe_q == {12{!$past(narrow_port_drive_n)}})
        else $error("narrow enable wrong");
    chk_wide_oe: assert property (1 |=> wideOe_q == {24{!$past(wide_port_drive_n)}})
        else $error("wide enable wrong");
    chk_sel_first: assert property (s && !wide_first_load_enable_n |-> ##2 narrowOut_q == $past(wideHalfFirstIn, 2))
        else $error("first half not routed");
    chk_sel_second: assert property (!s && !wide_second_load_enable_n |-> ##2 narrowOut_q == $past(wideHalfSecondIn, 2))
        else $error("second half not routed");
    chk_second_half: assert property (!e2 |-> ##2 wideHalfSecondOut_q == $past(narrowIn, 2))
        else $error("second half missed");
    chk_first_half: assert property (!e1 ##1 !e1 |-> ##2 wideHalfFirstOut_q == $past(narrowIn, 3))
        else $error("first half pipeline wrong");
    chk_wide_hold: assert property ((e1 && e2) [*3] |=> $stable(wideHalfFirstOut_q) && $stable(wideHalfSecondOut_q))
        else $error("wide halves moved");
    chk_narrow_hold: assert property ((wide_first_load_enable_n && wide_second_load_enable_n) [*2] |=> $stable(narrowOut_q))
        else $error("narrow output moved");
endmodule // nwbx_exchanger_chk
bind nwbx_exchanger nwbx_exchanger_chk u_chk (.clk, .reset, .narrowIn, .narrowOut_q, .narrowOe_q,
    .wideHalfFirstIn, .wideHalfSecondIn, .wideHalfFirstOut_q, .wideHalfSecondOut_q, .wideOe_q,
    .narrow_load_enable_first_n, .narrow_load_enable_second_n, .wide_first_load_enable_n,
    .wide_second_load_enable_n, .halfSelect_n, .narrow_port_drive_n, .wide_port_drive_n);

// ==== dv/nwbx_wide_model.sv ====
`timescale 1ns/1ps
module nwbx_wide_model (
    input wire clk,
    input wire [23:0] wideOe,
    input wire [23:0] devWord,
    output wire [23:0] lineWord
);
    reg [23:0] own_q = 24'h5A3C96;
    // The far bus changes its word every cycle so stale values never pass.
    always @(posedge clk) begin
        own_q <= {own_q[22:0], ~(own_q[23] ^ own_q[4])};
    end
    assign lineWord = wideOe[0] ? devWord : own_q;
endmodule // nwbx_wide_model

// ==== dv/narrow_to_wide_bus_exchanger_test.sv ====
`timescale 1ns/1ps
module narrow_to_wide_bus_exchanger_test;
    reg clk = 0;
    reg reset = 1;
    reg [11:0] aDrv = 12'h000;
    reg e1 = 1, e2 = 1, wf = 1, ws = 1, sel = 1, dA = 1, dB = 1;
    reg [15:0] lf = 16'h473C;
    integer n_fail = 0, samples_checked = 0, i;
    wire [11:0] narrowOut_q, narrowOe_q, wideHalfFirstOut_q, wideHalfSecondOut_q;
    wire [23:0] wideOe_q, lineWord;
    wire narrowReady_q, pipeBusy_q;
    // The narrow wire carries the device's value while it drives, else the bench's.
    wire [11:0] narrowIn = narrowOe_q[0] ? narrowOut_q : aDrv;
    nwbx_wide_model u_far (.clk, .wideOe(wideOe_q), .devWord({wideHalfSecondOut_q, wideHalfFirstOut_q}),
        .lineWord);
    nwbx_exchanger u_dut (.clk, .reset, .narrowIn, .narrowOut_q, .narrowOe_q,
        .wideHalfFirstIn(lineWord[11:0]), .wideHalfSecondIn(lineWord[23:12]), .wideHalfFirstOut_q,
        .wideHalfSecondOut_q, .wideOe_q, .narrow_load_enable_first_n(e1), .narrow_load_enable_second_n(e2),
        .wide_first_load_enable_n(wf), .wide_second_load_enable_n(ws), .halfSelect_n(sel),
        .narrow_port_drive_n(dA), .wide_port_drive_n(dB), .narrowReady_q, .pipeBusy_q);
    initial forever #4 clk = ~clk;
    function [15:0] lfsr(input [15:0] x);
        lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function [23:0] expOe(input d);
        expOe = {24{~d}};
    endfunction
    task check(input [79:0] nm, input [23:0] seen, input [23:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task pair(input [11:0] w0, input [11:0] w1);
        @(negedge clk) {aDrv, e1, e2} = {w0, 2'b01};
        @(negedge clk) {aDrv, e2} = {w1, 1'b0};
        @(negedge clk) {aDrv, e1, e2} = {~w1, 2'b11};
        check("busy", pipeBusy_q, 24'h000001);
        repeat (4) @(negedge clk);
        check("first", wideHalfFirstOut_q, w0);
        check("second", wideHalfSecondOut_q, w1);
        check("idle", pipeBusy_q, 24'h000000);
        check("ready", narrowReady_q, 24'h000001);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk) reset = 0;
        for (i = 0; i < 4; i = i + 1) begin
            @(negedge clk) {dA, dB} = i[1:0];
            @(negedge clk);
            check("narrowOe", narrowOe_q, expOe(dA) >> 12);
            check("wideOe", wideOe_q, expOe(dB));
        end
        dB = 0;
        pair(12'h000, 12'hFFF);
        pair(12'hFFF, 12'h000);
        pair(12'h5A1, 12'hA5E);
        // The wide port now carries the last pair, so each half can be fetched back.
        @(negedge clk) {sel, wf} = 2'b10;
        @(negedge clk) {sel, wf, ws} = 3'b010;
        @(negedge clk) ws = 1'b1;
        check("selFirst", narrowOut_q, 12'h5A1);
        @(negedge clk) sel = 1'b1;
        check("selSecond", narrowOut_q, 12'hA5E);
        repeat (2) @(negedge clk);
        check("aHold", narrowOut_q, 12'hA5E);
        for (i = 0; i < 400; i = i + 1) begin
            @(negedge clk) lf = lfsr(lf);
            {aDrv, e1, e2, wf, ws} = lf;
            {sel, dA, dB} = lf[9:7];
        end
        @(negedge clk) reset = 1;
        @(negedge clk);
        check("rstOe", {narrowOe_q, wideOe_q != 0}, 24'h0);
        tally_and_finish;
    end
    initial begin
        #20000;
        n_fail = n_fail + 1;
        tally_and_finish;
    end
endmodule // narrow_to_wide_bus_exchanger_test
